// ===== dv/timer_channel_control_tb.sv
`timescale 1ns/1ps

module timer_channel_control_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [5:0] drive_lvl = 6'h00;
	logic [5:0] pin_in;
	logic [5:0] pin_out;
	logic [5:0] pin_oe_n;
	logic [5:0] irq_req;
	logic [5:0] dma_req;
	logic [31:0] rd;
	int failures = 0;
	int samples_checked = 0;

	// Bus clock at 20 MHz.
	always #25 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////////////
	// The single slave's ready output closes the bus ready loop.
	tmrcc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.irq_req(irq_req), .dma_req(dma_req));

	tmrcc_pin_model pins (.drive_lvl(drive_lvl), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_in(pin_in));

	////////////////////////////////////////////////////////////////////////////////
	// Ends the run with the verdict.
	task results;
		if (failures == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One single word transfer; read data lands in rd at the end of the data phase.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	function automatic logic [7:0] csc_a(input int i);
		return tmrcc_pkg::ADDR_CSC_BASE + 8'(8 * i);
	endfunction

	// Disables the channel, lets the acknowledge pass, then writes the new mode.
	task set_mode(input int ch, input logic [7:0] cfg);
		bus(1'b1, csc_a(ch), 32'h80);
		repeat (2) @(posedge hclk);
		bus(1'b1, csc_a(ch), {24'h0, cfg});
	endtask

	// Waits a bounded time for the channel interrupt request.
	task wait_irq(input int ch);
		int n;
		n = 0;
		while (irq_req[ch] !== 1'b1 && n < 2000) begin
			@(posedge hclk);
			n++;
		end
		chk("irq wait", 32'(n < 2000), 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, reserved bits and the six register addresses.
	task t_regs;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, csc_a(i), 32'h0);
			chk("csc reset", rd, 32'h0);
			bus(1'b1, csc_a(i), 32'hffffffff);
			bus(1'b0, csc_a(i), 32'h0);
			chk("csc rw", rd, 32'h7d);
			set_mode(i, 8'h00);
			bus(1'b0, csc_a(i), 32'h0);
			chk("csc off", rd, 32'h0);
			chk("oe off", pin_oe_n[i], 1'b1);
		end
		bus(1'b1, 8'h3c, 32'hff);
		bus(1'b0, 8'h3c, 32'h0);
		chk("unmapped", rd, 32'h0);
	endtask

	// Capture edge selection, masked interrupt and the flag clearing rules.
	task t_capture;
		for (int e = 1; e < 4; e++) begin
			set_mode(1, 8'(e << 2));
			drive_lvl[1] <= 1'b1;
			repeat (4) @(posedge hclk);
			bus(1'b0, csc_a(1), 32'h0);
			chk("cap rise", rd[7], e != 2);
			chk("irq masked", irq_req[1], 1'b0);
			bus(1'b1, csc_a(1), 32'h80 | (e << 2));
			drive_lvl[1] <= 1'b0;
			repeat (4) @(posedge hclk);
			bus(1'b0, csc_a(1), 32'h0);
			chk("cap fall", rd[7], e != 1);
		end
		bus(1'b1, csc_a(1), 32'h8c);
		drive_lvl[1] <= 1'b1;
		repeat (4) @(posedge hclk);
		drive_lvl[1] <= 1'b0;
		repeat (4) @(posedge hclk);
		bus(1'b1, csc_a(1), 32'h8c);
		bus(1'b0, csc_a(1), 32'h0);
		chk("overrun", rd[7], 1'b1);
		bus(1'b1, csc_a(1), 32'h0c);
		bus(1'b0, csc_a(1), 32'h0);
		chk("w0 keep", rd[7], 1'b1);
		bus(1'b1, csc_a(1), 32'h8c);
		bus(1'b0, csc_a(1), 32'h0);
		chk("w1 clear", rd[7], 1'b0);
	endtask

	// Stops and clears the counter, selecting the chosen counting mode, modulo 0xff and match value 3 on the chosen channel.
	task restart(input int ch, input logic cp);
		bus(1'b1, tmrcc_pkg::ADDR_CTRL, 32'h0);
		bus(1'b1, tmrcc_pkg::ADDR_CTRL, {26'h0, cp, 5'h0});
		bus(1'b1, tmrcc_pkg::ADDR_COUNT, 32'h0);
		bus(1'b1, tmrcc_pkg::ADDR_MOD, 32'hff);
		bus(1'b1, tmrcc_pkg::ADDR_VAL_BASE + 8'(8 * ch), 32'h3);
	endtask

	// Software compare flags the match but leaves the pin alone.
	task t_soft;
		restart(0, 1'b0);
		set_mode(0, 8'hd0);
		bus(1'b1, tmrcc_pkg::ADDR_CTRL, 32'h1);
		wait_irq(0);
		chk("soft oe", pin_oe_n[0], 1'b1);
	endtask

	// Output mode on channel 2: level at the match and cycles until the next change.
	task t_out(input logic [1:0] ms, input logic [1:0] el, input logic cp, input logic lvl,
		input int span, input logic dm);
		int n;
		restart(2, cp);
		set_mode(2, {2'b11, ms, el, 1'b0, dm});
		bus(1'b1, tmrcc_pkg::ADDR_CTRL, {26'h0, cp, 5'h1});
		wait_irq(2);
		chk("match lvl", pin_out[2], lvl);
		chk("drive oe", pin_oe_n[2], 1'b0);
		chk("dma", dma_req[2], dm);
		n = 0;
		while (pin_out[2] === lvl && n < 1000) begin
			@(posedge hclk);
			n++;
		end
		if (span > 0) begin
			chk("span", n, span);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence after the reset pulse.
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_capture();
		t_soft();
		t_out(2'b01, 2'b11, 1'b0, 1'b1, 0, 1'b0);
		t_out(2'b01, 2'b10, 1'b0, 1'b0, 0, 1'b0);
		t_out(2'b01, 2'b01, 1'b0, 1'b1, 256, 1'b1);
		t_out(2'b11, 2'b10, 1'b0, 1'b0, 1, 1'b0);
		t_out(2'b11, 2'b01, 1'b0, 1'b1, 1, 1'b0);
		t_out(2'b11, 2'b11, 1'b0, 1'b1, 1, 1'b0);
		t_out(2'b10, 2'b10, 1'b0, 1'b0, 252, 1'b0);
		t_out(2'b10, 2'b11, 1'b0, 1'b1, 252, 1'b0);
		t_out(2'b10, 2'b10, 1'b1, 1'b0, 504, 1'b0);
		t_out(2'b10, 2'b01, 1'b1, 1'b1, 504, 1'b0);
		results();
	end

	// Cuts a hang short well beyond the expected length of the run.
	initial begin
		repeat (40000) @(posedge hclk);
		failures++;
		results();
	end
endmodule // timer_channel_control_tb

// ===== dv/tmrcc_pin_model.sv
`timescale 1ns/1ps

// Far side of the channel pins: an external source drives each pin unless the channel does.
module tmrcc_pin_model (
	input wire logic [5:0] drive_lvl,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe_n,
	output logic [5:0] pin_in
);
	// The wire level seen by the channel input is whoever drives it at the moment.
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & drive_lvl);
endmodule // tmrcc_pin_model

// ===== src/tmrcc_channel.sv
`timescale 1ns/1ps

module tmrcc_channel #(
	parameter int CNT_W = tmrcc_pkg::CNT_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic csc_we,
	input tmrcc_pkg::tmrcc_csc_t csc_wdata,
	input wire logic val_we,
	input wire logic [CNT_W-1:0] val_wdata,
	input wire logic cpwm,
	input wire logic count_run,
	input wire logic count_down,
	input wire logic [CNT_W-1:0] count,
	input wire logic reload,
	input wire logic pin_in,
	output tmrcc_pkg::tmrcc_csc_t csc_rd,
	output logic [CNT_W-1:0] val_rd,
	output logic pin_out,
	output logic pin_oe_n,
	output logic irq_req,
	output logic dma_req
);

	////////////////////////////////////////////////////////////////////////////////
	tmrcc_pkg::tmrcc_csc_t csc_ff;
	logic dis_pend_ff;
	logic ovr_ff;
	logic [CNT_W-1:0] val_ff;
	logic out_ff;
	logic pin_prev_ff;
	logic dma_ff;
	logic nxt_out;

	// Mode decode from the accepted configuration.
	wire logic [1:0] el = csc_ff.edge_sel;
	wire logic cfg_off = (csc_ff.mode == tmrcc_pkg::MS_NONE) && (el == tmrcc_pkg::EL_OFF);
	wire logic new_off = (csc_wdata.mode == tmrcc_pkg::MS_NONE) &&
		(csc_wdata.edge_sel == tmrcc_pkg::EL_OFF);
	wire logic is_swcmp = (csc_ff.mode != tmrcc_pkg::MS_NONE) && (el == tmrcc_pkg::EL_OFF);
	wire logic el_on = (el != tmrcc_pkg::EL_OFF);
	wire logic is_capture = !cpwm && (csc_ff.mode == tmrcc_pkg::MS_NONE) && el_on;
	wire logic is_cmp = !cpwm && (csc_ff.mode == tmrcc_pkg::MS_COMPARE) && el_on;
	wire logic is_pulse = !cpwm && (csc_ff.mode == tmrcc_pkg::MS_PULSE) && el_on;
	wire logic is_epwm = !cpwm && (csc_ff.mode == tmrcc_pkg::MS_PWM) && el_on;
	wire logic is_cpwm = cpwm && (csc_ff.mode == tmrcc_pkg::MS_PWM) && el_on;

	// Edge detection on the pin and match detection on the counter.
	wire logic rise = pin_in && !pin_prev_ff;
	wire logic fall = !pin_in && pin_prev_ff;
	wire logic cap_hit = is_capture && ((el[0] && rise) || (el[1] && fall));
	wire logic cmp_mode = is_swcmp || is_cmp || is_pulse || is_epwm || is_cpwm;
	wire logic match = count_run && cmp_mode && (count == val_ff);
	wire logic chan_event = cap_hit || match;
	wire logic clr_req = csc_we && csc_wdata.flag;
	wire logic cfg_wr = csc_we && !dis_pend_ff;

	// Output level for the next cycle, by mode.
	always_comb begin
		nxt_out = out_ff;
		if (is_cmp && match) begin
			case (el)
				tmrcc_pkg::EL_RISE: nxt_out = !out_ff;
				tmrcc_pkg::EL_FALL: nxt_out = 1'b0;
				tmrcc_pkg::EL_BOTH: nxt_out = 1'b1;
				default: nxt_out = out_ff;
			endcase
		end else if (is_pulse) begin
			nxt_out = el[0] ? match : !match;
		end else if (is_epwm && match) begin
			nxt_out = el[0];
		end else if (is_epwm && reload) begin
			nxt_out = !el[0];
		end else if (is_cpwm && match) begin
			nxt_out = el[0] ^ count_down;
		end
	end

	// Flag with overrun memory, so a clear after a second event only ends the overrun and leaves the flag set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			csc_ff.flag <= 1'b0;
			ovr_ff <= 1'b0;
		end else begin
			csc_ff.flag <= chan_event || (csc_ff.flag && !(clr_req && !ovr_ff));
			ovr_ff <= (chan_event && csc_ff.flag) || (ovr_ff && !clr_req);
		end
	end

	// Configuration; a disable is acknowledged one cycle later through dis_pend_ff in this block.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			csc_ff.irq_en <= 1'b0;
			csc_ff.dma_en <= 1'b0;
			csc_ff.mode <= tmrcc_pkg::MS_NONE;
			csc_ff.edge_sel <= tmrcc_pkg::EL_OFF;
			csc_ff.rsv <= 1'b0;
			dis_pend_ff <= 1'b0;
		end else begin
			if (csc_we) begin
				csc_ff.irq_en <= csc_wdata.irq_en;
				csc_ff.dma_en <= csc_wdata.dma_en;
			end
			if (dis_pend_ff) begin
				csc_ff.mode <= tmrcc_pkg::MS_NONE;
				csc_ff.edge_sel <= tmrcc_pkg::EL_OFF;
				dis_pend_ff <= 1'b0;
			end else if (cfg_wr && new_off && !cfg_off) begin
				dis_pend_ff <= 1'b1;
			end else if (cfg_wr && !new_off) begin
				csc_ff.mode <= csc_wdata.mode;
				csc_ff.edge_sel <= csc_wdata.edge_sel;
			end
		end
	end

	// Channel value, pin history, output and request pulse.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			val_ff <= '0;
			out_ff <= 1'b0;
			pin_prev_ff <= 1'b0;
			dma_ff <= 1'b0;
		end else begin
			if (cap_hit) begin
				val_ff <= count;
			end else if (val_we && !is_capture) begin
				val_ff <= val_wdata;
			end
			out_ff <= nxt_out;
			pin_prev_ff <= pin_in;
			dma_ff <= chan_event && csc_ff.dma_en;
		end
	end

	// Register view and pin drive.
	assign csc_rd = csc_ff;
	assign val_rd = val_ff;
	assign pin_out = out_ff;
	assign pin_oe_n = !(is_cmp || is_pulse || is_epwm || is_cpwm);
	assign irq_req = csc_ff.flag && csc_ff.irq_en;
	assign dma_req = dma_ff;

	////////////////////////////////////////////////////////////////////////////////
	chk_pin_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		(cfg_off || is_swcmp || is_capture) |-> pin_oe_n)
		else $error("Pin driven while channel does not own it.");
	chk_rise_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_capture && el == tmrcc_pkg::EL_RISE && rise) |=> (val_ff == $past(count) && csc_ff.flag))
		else $error("Rising edge not captured.");
	chk_fall_only: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_capture && el == tmrcc_pkg::EL_FALL && rise && !val_we) |=> $stable(val_ff))
		else $error("Rising edge captured in falling-only mode.");
	chk_toggle_match: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_cmp && el == tmrcc_pkg::EL_RISE && match) |=> (out_ff != $past(out_ff)))
		else $error("Output did not toggle on match.");
	chk_clear_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_cmp && el[1] && match) |=> (out_ff == $past(el[0])))
		else $error("Output compare level wrong after match.");
	chk_pulse_width: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_pulse && match ##1 (is_pulse && !match && $stable(el))) |=>
		(out_ff == !el[0] && $past(out_ff) == el[0]))
		else $error("Match pulse is not one cycle wide.");
	chk_edge_pwm: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_epwm && reload && !match) |=> (out_ff == !$past(el[0])))
		else $error("Edge PWM level wrong after reload.");
	chk_center_pwm: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_cpwm && match) |=> (out_ff == ($past(el[0]) ^ $past(count_down))))
		else $error("Center PWM level wrong after match.");
	chk_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(clr_req && csc_ff.flag && !ovr_ff && !chan_event) |=> !csc_ff.flag)
		else $error("Flag not cleared by write of one.");
	chk_flag_kept: assert property (@(posedge hclk) disable iff (!hresetn)
		(clr_req && csc_ff.flag && ovr_ff) |=> csc_ff.flag)
		else $error("Flag lost after a second event.");
	chk_mode_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(dis_pend_ff) |-> ($stable(csc_ff.mode) ##1 (csc_ff.mode == tmrcc_pkg::MS_NONE)))
		else $error("Mode bits changed before disable acknowledge.");
	chk_dma_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		(chan_event && csc_ff.dma_en) |=> (dma_req ##1 !dma_req || $past(chan_event)))
		else $error("DMA request missing after event.");

endmodule // tmrcc_channel

// ===== src/tmrcc_pkg.sv
package tmrcc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses within the block window.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_MOD = 8'h08;
	localparam logic [7:0] ADDR_CSC_BASE = 8'h0c;
	localparam logic [7:0] ADDR_VAL_BASE = 8'h10;
	localparam int NUM_CHAN = 6;
	localparam int CNT_W = 16;

	// Field positions of the block control register.
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CPWM_BIT = 5;

	// Field positions of each channel_status_control register.
	localparam int CSC_FLAG_BIT = 7;
	localparam int CSC_DMA_BIT = 0;
	localparam int CSC_RSV_BIT = 1;

	// Reset values.
	localparam logic [7:0] CSC_RESET = 8'h00;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [15:0] MOD_RESET = 16'hffff;

	// Bus encodings.
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;

	// Channel mode pair encodings.
	typedef enum logic [1:0] {
		MS_NONE = 2'h0,
		MS_COMPARE = 2'h1,
		MS_PULSE = 2'h3,
		MS_PWM = 2'h2
	} tmrcc_mode_t;

	// Edge or level pair encodings.
	localparam logic [1:0] EL_OFF = 2'h0;
	localparam logic [1:0] EL_RISE = 2'h1;
	localparam logic [1:0] EL_FALL = 2'h2;
	localparam logic [1:0] EL_BOTH = 2'h3;

	// Low byte of a channel_status_control register.
	typedef struct packed {
		logic flag;
		logic irq_en;
		tmrcc_mode_t mode;
		logic [1:0] edge_sel;
		logic rsv;
		logic dma_en;
	} tmrcc_csc_t;

endpackage

// ===== src/tmrcc_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Mode 00 with edge 00 disables; nonzero mode with edge 00 is software compare.
// - Input capture with edge 01 captures the count on rising edges only.
// - Input capture edge 10 captures falling edges, edge 11 captures both.
// - Output compare with edge 01 toggles the output on each match.
// - Output compare edge 10 clears on match, edge 11 sets on match.
// - Mode 11 with edge 10 pulses the output low on a match.
// - Mode 11 with edge low bit set pulses the output high on match.
// - Edge PWM edge 10: output low on match, high at reload.
// - Edge PWM with edge low bit set: output high on match, low at reload.
// - Center PWM edge 10 clears on up match, sets on down match; X1 opposite.
// - Hardware sets the channel flag on events; writing one clears, zero keeps.
// - A clear after a further event leaves the flag set.
// - Interrupt enable passes or blocks channel interrupt requests.
// - DMA enable passes or blocks channel DMA requests.
// - After disable, mode and edge bits hold until the acknowledge.
// - Bits 31 to 8 and bit 1 of channel control read zero.
// - Six channel control registers at offset 0xc plus eight times index.
// - Center PWM select makes the counter count up then down, else up only.
module tmrcc_top #(
	parameter int CH = tmrcc_pkg::NUM_CHAN,
	parameter int CNT_W = tmrcc_pkg::CNT_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [CH-1:0] pin_in,
	output logic [CH-1:0] pin_out,
	output logic [CH-1:0] pin_oe_n,
	output logic [CH-1:0] irq_req,
	output logic [CH-1:0] dma_req
);

	////////////////////////////////////////////////////////////////////////////////
	// Returns a hit flag and channel index for a per-channel register array.
	function automatic logic [3:0] slot_of(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] off;
		off = a - base;
		slot_of = {(a >= base) && (off[2:0] == 3'h0) && (off[7:3] < 5'(CH)), off[5:3]};
	endfunction

	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_word;
	logic run_ff;
	logic cpwm_ff;
	logic [CNT_W-1:0] mod_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic down_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic nxt_down;
	tmrcc_pkg::tmrcc_csc_t csc_rd [CH];
	logic [CNT_W-1:0] val_rd [CH];

	////////////////////////////////////////////////////////////////////////////////
	// Address phase decode and data phase write decode.
	wire logic acc = hsel && hready && htrans[tmrcc_pkg::HTRANS_ACTIVE_BIT];
	wire logic rd_acc = acc && !hwrite;
	wire logic [7:0] ra = haddr[7:0];
	wire logic [3:0] rd_csc = slot_of(ra, tmrcc_pkg::ADDR_CSC_BASE);
	wire logic [3:0] rd_val = slot_of(ra, tmrcc_pkg::ADDR_VAL_BASE);
	wire logic [3:0] wr_csc = slot_of(wr_addr_ff, tmrcc_pkg::ADDR_CSC_BASE);
	wire logic [3:0] wr_val = slot_of(wr_addr_ff, tmrcc_pkg::ADDR_VAL_BASE);
	wire logic wr_ctrl = wr_pend_ff && (wr_addr_ff == tmrcc_pkg::ADDR_CTRL);
	wire logic wr_mod = wr_pend_ff && (wr_addr_ff == tmrcc_pkg::ADDR_MOD);
	wire logic [CNT_W-1:0] wdata_cnt = hwdata[CNT_W-1:0];
	wire tmrcc_pkg::tmrcc_csc_t wdata_csc = hwdata[7:0];

	// Zero-wait slave; every answer is OKAY.
	assign hreadyout = 1'b1;
	assign hresp = tmrcc_pkg::HRESP_OKAY;
	assign hrdata = hrdata_ff;

	// Read mux; unmapped addresses and reserved bits read zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		case (ra)
			tmrcc_pkg::ADDR_CTRL: begin
				rd_word[tmrcc_pkg::CTRL_RUN_BIT] = run_ff;
				rd_word[tmrcc_pkg::CTRL_CPWM_BIT] = cpwm_ff;
			end
			tmrcc_pkg::ADDR_COUNT: rd_word[CNT_W-1:0] = cnt_ff;
			tmrcc_pkg::ADDR_MOD: rd_word[CNT_W-1:0] = mod_ff;
			default: begin
				if (rd_csc[3]) begin
					rd_word[7:0] = csc_rd[rd_csc[2:0]];
					rd_word[tmrcc_pkg::CSC_RSV_BIT] = 1'b0;
				end else if (rd_val[3]) begin
					rd_word[CNT_W-1:0] = val_rd[rd_val[2:0]];
				end
			end
		endcase
	end

	// Bus pipeline: address captured, read data loaded at the address edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= acc && hwrite;
			if (acc) begin
				wr_addr_ff <= ra;
			end
			if (rd_acc) begin
				hrdata_ff <= rd_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Block control: counter run and center PWM select, modulo value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_ff <= tmrcc_pkg::CTRL_RESET[0];
			cpwm_ff <= tmrcc_pkg::CTRL_RESET[1];
			mod_ff <= tmrcc_pkg::MOD_RESET;
		end else begin
			if (wr_ctrl) begin
				run_ff <= hwdata[tmrcc_pkg::CTRL_RUN_BIT];
			end
			if (wr_ctrl && !run_ff) begin
				cpwm_ff <= hwdata[tmrcc_pkg::CTRL_CPWM_BIT];
			end
			if (wr_mod) begin
				mod_ff <= wdata_cnt;
			end
		end
	end

	// Counter reload marks the start of each PWM period.
	wire logic at_mod = (cnt_ff >= mod_ff);
	wire logic at_zero = (cnt_ff == '0);
	wire logic reload = run_ff && (cpwm_ff ? (down_ff && at_zero) : at_mod);

	// Up counting wraps at the modulo; center mode turns at modulo and at zero.
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_down = down_ff;
		if (!cpwm_ff) begin
			nxt_down = 1'b0;
			if (run_ff) begin
				nxt_cnt = at_mod ? '0 : cnt_ff + 1'b1;
			end
		end else if (run_ff) begin
			if (!down_ff && at_mod) begin
				nxt_down = (mod_ff != '0);
				nxt_cnt = (mod_ff == '0) ? '0 : cnt_ff - 1'b1;
			end else if (down_ff && at_zero) begin
				nxt_down = 1'b0;
				nxt_cnt = cnt_ff + 1'b1;
			end else begin
				nxt_cnt = down_ff ? cnt_ff - 1'b1 : cnt_ff + 1'b1;
			end
		end
	end

	// Counter state; a bus write to the count register clears it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= '0;
			down_ff <= 1'b0;
		end else if (wr_pend_ff && (wr_addr_ff == tmrcc_pkg::ADDR_COUNT)) begin
			cnt_ff <= '0;
			down_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			down_ff <= nxt_down;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One channel per pin.
	for (genvar i = 0; i < CH; i++) begin : g_chan
		tmrcc_channel #(
			.CNT_W(CNT_W)
		) u_chan (
			.hclk(hclk),
			.hresetn(hresetn),
			.csc_we(wr_pend_ff && wr_csc[3] && (wr_csc[2:0] == 3'(i))),
			.csc_wdata(wdata_csc),
			.val_we(wr_pend_ff && wr_val[3] && (wr_val[2:0] == 3'(i))),
			.val_wdata(wdata_cnt),
			.cpwm(cpwm_ff),
			.count_run(run_ff),
			.count_down(down_ff),
			.count(cnt_ff),
			.reload(reload),
			.pin_in(pin_in[i]),
			.csc_rd(csc_rd[i]),
			.val_rd(val_rd[i]),
			.pin_out(pin_out[i]),
			.pin_oe_n(pin_oe_n[i]),
			.irq_req(irq_req[i]),
			.dma_req(dma_req[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	chk_csc_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_acc && rd_csc[3]) |=> (hrdata[31:8] == 24'h00_0000 && !hrdata[1]))
		else $error("Reserved channel control bits read nonzero.");
	chk_csc_write_map: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend_ff && wr_csc[3] && hwdata[6]) |=> irq_req[wr_csc[2:0]] == csc_rd[wr_csc[2:0]].flag)
		else $error("Channel control write reached the wrong channel.");
	chk_up_count: assert property (@(posedge hclk) disable iff (!hresetn)
		(run_ff && !cpwm_ff && !at_mod && !wr_pend_ff) |=> (cnt_ff == $past(cnt_ff) + 1'b1))
		else $error("Counter did not count up.");
	chk_turn_down: assert property (@(posedge hclk) disable iff (!hresetn)
		(run_ff && cpwm_ff && !down_ff && at_mod && mod_ff != '0 && !wr_pend_ff) |=> down_ff)
		else $error("Center mode counter did not turn down.");
	chk_up_only: assert property (@(posedge hclk) disable iff (!hresetn)
		!cpwm_ff |=> !down_ff)
		else $error("Counter counted down outside center mode.");

endmodule // tmrcc_top
